// ===== src/pcqs_pkg.sv
// Operation
// - far-end fault enable bit, resets to one
// - alternate next-page enable bit, resets to zero
// - writing fiber bit one selects fiber mode
// - fiber bit reset value follows media strap
// - status bit 14 shows 100 Mbps twisted pair
// - status bit 13 shows packet transmission
// - status bit 12 shows packet reception
// - status bit 11 shows collision
// - status bit 10 shows link up
// - status bit 9 shows full duplex
// - status bit 8 shows auto-negotiation mode
package pcqs_pkg;

	// ==========================================
	// register map
	localparam logic [4:0] REG_CFG = 5'h10;
	localparam logic [4:0] REG_STATUS = 5'h11;

	// configuration field positions and reset values
	localparam int CFG_FEF_BIT = 2;
	localparam int CFG_ANP_BIT = 1;
	localparam int CFG_FIBER_BIT = 0;
	localparam logic CFG_FEF_RST = 1'h1;
	localparam logic CFG_ANP_RST = 1'h0;

	// quick status field positions
	localparam int QS_SPEED_BIT = 14;
	localparam int QS_TX_BIT = 13;
	localparam int QS_RX_BIT = 12;
	localparam int QS_COL_BIT = 11;
	localparam int QS_LINK_BIT = 10;
	localparam int QS_DUPLEX_BIT = 9;
	localparam int QS_AN_BIT = 8;

	// ==========================================
	// management frame layout
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [5:0] HDR_LEN = 6'h0d;
	localparam logic [5:0] TA_LEN = 6'h02;
	localparam logic [5:0] DATA_LEN = 6'h10;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	// ==========================================
	// types
	typedef struct packed {
		logic speed100_tp;
		logic tx_active;
		logic rx_active;
		logic collision;
		logic link_up;
		logic full_duplex;
		logic autoneg_mode;
	} pcqs_live_t;

	typedef struct packed {
		logic far_end_fault_enable;
		logic alt_next_page_enable;
		logic fiber_mode;
	} pcqs_cfg_t;

	typedef enum logic [2:0] {
		S_PRE,
		S_HDR,
		S_RTA,
		S_RDATA,
		S_WTA,
		S_WDATA
	} pcqs_state_t;

endpackage

// ===== src/pcqs_sync.sv
// ==========================================
// two-stage synchroniser for pin inputs
module pcqs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk, // system clock
	input wire logic [WIDTH-1:0] d, // asynchronous input
	output logic [WIDTH-1:0] q // synchronised output
);
	logic [WIDTH-1:0] meta_q;

	// no reset, so the strap level gets through while reset is held; first stage read only by the second
	always_ff @(posedge mclk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule

// ===== src/pcqs_rise.sv
// ==========================================
// rising edge detector on a synchronised level
module pcqs_rise (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic lvl, // synchronised level
	output logic rise // one-cycle pulse on rising edge
);
	logic last_q;

	// history of the level
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			last_q <= 1'h0;
		end else begin
			last_q <= lvl;
		end
	end

	assign rise = lvl & ~last_q;
endmodule

// ===== src/pcqs_top.sv
// ==========================================
// per-port config and quick status, reached over the management pins
module pcqs_top #(
	parameter logic [4:0] PORT_ADDR = 5'h00
) (
	input wire logic mclk, // 20 MHz system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic mdc, // management clock pin
	input wire logic mdio_in, // management data pin, input
	output logic mdio_out, // management data pin, output
	output logic mdio_oe, // management data pin, drive enable
	input wire logic media_strap_pin, // media strap, low means twisted pair
	input pcqs_pkg::pcqs_live_t live, // live port state, same clock
	output pcqs_pkg::pcqs_cfg_t cfg // configuration to port logic
);
	logic mdc_s;
	logic mdio_s;
	logic strap_s;
	logic mdc_rise;
	pcqs_pkg::pcqs_state_t state_q;
	logic [5:0] cnt_q;
	logic [12:0] hdr_q;
	logic [15:0] shift_q;
	logic [4:0] reg_q;
	logic [15:0] cfg_word;
	logic [15:0] status_word;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic wr_stb;
	logic cfg_we;
	logic hdr_done;
	logic [1:0] hdr_op;
	logic [4:0] hdr_phy;
	logic [4:0] hdr_reg;
	logic status_load;

	// ==========================================
	// pin synchronisation
	pcqs_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk(mclk),
		.d({mdc, mdio_in, media_strap_pin}),
		.q({mdc_s, mdio_s, strap_s})
	);

	// mdc and mdio share one delay, so sampling stays aligned
	pcqs_rise u_rise (
		.mclk(mclk),
		.rst_n(rst_n),
		.lvl(mdc_s),
		.rise(mdc_rise)
	);

	// ==========================================
	// register read values
	always_comb begin
		cfg_word = '0;
		cfg_word[pcqs_pkg::CFG_FEF_BIT] = cfg.far_end_fault_enable;
		cfg_word[pcqs_pkg::CFG_ANP_BIT] = cfg.alt_next_page_enable;
		cfg_word[pcqs_pkg::CFG_FIBER_BIT] = cfg.fiber_mode;
	end

	// live, unlatched view of the port; lower byte and bit 15 read zero
	always_comb begin
		status_word = '0;
		status_word[pcqs_pkg::QS_SPEED_BIT] = live.speed100_tp;
		status_word[pcqs_pkg::QS_TX_BIT] = live.tx_active;
		status_word[pcqs_pkg::QS_RX_BIT] = live.rx_active;
		status_word[pcqs_pkg::QS_COL_BIT] = live.collision;
		status_word[pcqs_pkg::QS_LINK_BIT] = live.link_up;
		status_word[pcqs_pkg::QS_DUPLEX_BIT] = live.full_duplex;
		status_word[pcqs_pkg::QS_AN_BIT] = live.autoneg_mode;
	end

	// unmapped registers read as zero
	always_comb begin
		if (reg_q == pcqs_pkg::REG_CFG) begin
			rd_word = cfg_word;
		end else if (reg_q == pcqs_pkg::REG_STATUS) begin
			rd_word = status_word;
		end else begin
			rd_word = '0;
		end
	end

	// ==========================================
	// frame decode helpers
	assign hdr_done = (state_q == pcqs_pkg::S_HDR) && mdc_rise && (cnt_q == pcqs_pkg::HDR_LEN - 6'h01);
	assign hdr_op = hdr_q[10:9];
	assign hdr_phy = hdr_q[8:4];
	assign hdr_reg = {hdr_q[3:0], mdio_s};
	assign wr_word = {shift_q[14:0], mdio_s};
	assign wr_stb = (state_q == pcqs_pkg::S_WDATA) && mdc_rise && (cnt_q == pcqs_pkg::DATA_LEN - 6'h01);
	// writes to the quick status or unmapped registers fall away
	assign cfg_we = wr_stb && (reg_q == pcqs_pkg::REG_CFG);
	assign status_load = (state_q == pcqs_pkg::S_RTA) && mdc_rise && (reg_q == pcqs_pkg::REG_STATUS);

	// ==========================================
	// management frame sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= pcqs_pkg::S_PRE;
			cnt_q <= '0;
			hdr_q <= '0;
			reg_q <= '0;
		end else if (mdc_rise) begin
			case (state_q)
				pcqs_pkg::S_PRE: begin
					if (mdio_s) begin
						if (cnt_q != pcqs_pkg::PREAMBLE_LEN) begin
							cnt_q <= cnt_q + 6'h01;
						end
					end else if (cnt_q == pcqs_pkg::PREAMBLE_LEN) begin
						// first start bit after a full preamble
						state_q <= pcqs_pkg::S_HDR;
						cnt_q <= '0;
					end else begin
						cnt_q <= '0;
					end
				end
				pcqs_pkg::S_HDR: begin
					hdr_q <= {hdr_q[11:0], mdio_s};
					cnt_q <= cnt_q + 6'h01;
					if (hdr_done) begin
						cnt_q <= '0;
						reg_q <= hdr_reg;
						// frames for other ports or bad start bits go back to hunting
						if (!hdr_q[11] || hdr_phy != PORT_ADDR) begin
							state_q <= pcqs_pkg::S_PRE;
						end else if (hdr_op == pcqs_pkg::OP_READ) begin
							state_q <= pcqs_pkg::S_RTA;
						end else if (hdr_op == pcqs_pkg::OP_WRITE) begin
							state_q <= pcqs_pkg::S_WTA;
						end else begin
							state_q <= pcqs_pkg::S_PRE;
						end
					end
				end
				pcqs_pkg::S_RTA: begin
					state_q <= pcqs_pkg::S_RDATA;
				end
				pcqs_pkg::S_RDATA: begin
					if (cnt_q == pcqs_pkg::DATA_LEN) begin
						state_q <= pcqs_pkg::S_PRE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				pcqs_pkg::S_WTA: begin
					if (cnt_q == pcqs_pkg::TA_LEN - 6'h01) begin
						state_q <= pcqs_pkg::S_WDATA;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				pcqs_pkg::S_WDATA: begin
					if (wr_stb) begin
						state_q <= pcqs_pkg::S_PRE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= pcqs_pkg::S_PRE;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// ==========================================
	// data shifter and pin drive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_q <= '0;
			mdio_out <= 1'h0;
			mdio_oe <= 1'h0;
		end else if (mdc_rise) begin
			case (state_q)
				pcqs_pkg::S_RTA: begin
					// second turnaround bit: drive zero, snapshot the word
					shift_q <= rd_word;
					mdio_out <= 1'h0;
					mdio_oe <= 1'h1;
				end
				pcqs_pkg::S_RDATA: begin
					if (cnt_q == pcqs_pkg::DATA_LEN) begin
						mdio_oe <= 1'h0;
						mdio_out <= 1'h0;
					end else begin
						mdio_out <= shift_q[15];
						shift_q <= {shift_q[14:0], 1'h0};
					end
				end
				pcqs_pkg::S_WDATA: begin
					shift_q <= wr_word;
				end
				default: begin
					mdio_oe <= 1'h0;
					mdio_out <= 1'h0;
				end
			endcase
		end
	end

	// ==========================================
	// configuration bits; strap caught while reset is held
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg.far_end_fault_enable <= pcqs_pkg::CFG_FEF_RST;
			cfg.alt_next_page_enable <= pcqs_pkg::CFG_ANP_RST;
			cfg.fiber_mode <= strap_s;
		end else if (cfg_we) begin
			// reserved bits of the word are simply dropped
			cfg.far_end_fault_enable <= wr_word[pcqs_pkg::CFG_FEF_BIT];
			cfg.alt_next_page_enable <= wr_word[pcqs_pkg::CFG_ANP_BIT];
			cfg.fiber_mode <= wr_word[pcqs_pkg::CFG_FIBER_BIT];
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// read frame steps: header, turnaround, data bits, release
	sequence s_read_hdr;
		hdr_done && hdr_q[11] && hdr_phy == PORT_ADDR && hdr_op == pcqs_pkg::OP_READ;
	endsequence

	sequence s_ta_rise;
		state_q == pcqs_pkg::S_RTA && mdc_rise;
	endsequence

	sequence s_ta_drive;
		mdio_oe && !mdio_out;
	endsequence

	sequence s_cfg_load;
		state_q == pcqs_pkg::S_RTA && mdc_rise && reg_q == pcqs_pkg::REG_CFG;
	endsequence

	sequence s_data_rise;
		state_q == pcqs_pkg::S_RDATA && mdc_rise && cnt_q != pcqs_pkg::DATA_LEN;
	endsequence

	sequence s_data_end;
		state_q == pcqs_pkg::S_RDATA && mdc_rise && cnt_q == pcqs_pkg::DATA_LEN;
	endsequence

	fef_reset_one_a: assert property ($rose(rst_n) |-> cfg.far_end_fault_enable)
		else $error("far-end fault enable not one after reset");
	fef_write_a: assert property (cfg_we |=> cfg.far_end_fault_enable == $past(wr_word[pcqs_pkg::CFG_FEF_BIT]))
		else $error("far-end fault enable not written");
	anp_reset_zero_a: assert property ($rose(rst_n) |-> !cfg.alt_next_page_enable)
		else $error("alternate next page not zero after reset");
	fiber_write_a: assert property (cfg_we |=> cfg.fiber_mode == $past(wr_word[pcqs_pkg::CFG_FIBER_BIT]))
		else $error("fiber mode not written");
	fiber_strap_a: assert property ($rose(rst_n) |-> cfg.fiber_mode == $past(strap_s))
		else $error("fiber mode reset value differs from strap");
	speed_load_a: assert property (status_load |=> shift_q[15:14] == {1'h0, $past(live.speed100_tp)})
		else $error("speed bit not loaded from port");
	tx_load_a: assert property (status_load |=> shift_q[pcqs_pkg::QS_TX_BIT] == $past(live.tx_active))
		else $error("transmit bit not loaded from port");
	rx_load_a: assert property (status_load |=> shift_q[pcqs_pkg::QS_RX_BIT] == $past(live.rx_active))
		else $error("receive bit not loaded from port");
	col_load_a: assert property (status_load |=> shift_q[pcqs_pkg::QS_COL_BIT] == $past(live.collision))
		else $error("collision bit not loaded from port");
	link_load_a: assert property (status_load |=> shift_q[pcqs_pkg::QS_LINK_BIT] == $past(live.link_up))
		else $error("link bit not loaded from port");
	duplex_load_a: assert property (status_load |=> shift_q[pcqs_pkg::QS_DUPLEX_BIT] == $past(live.full_duplex))
		else $error("duplex bit not loaded from port");
	an_load_a: assert property (status_load |=> shift_q[8:0] == {$past(live.autoneg_mode), 8'h00})
		else $error("auto-negotiation bit not loaded from port");
	status_write_a: assert property (wr_stb && reg_q == pcqs_pkg::REG_STATUS |=> $stable(cfg))
		else $error("status write changed configuration");
	ta_drive_a: assert property (s_ta_rise |=> s_ta_drive)
		else $error("turnaround drive wrong");
	ta_idle_a: assert property (s_read_hdr |=> state_q == pcqs_pkg::S_RTA && !mdio_oe)
		else $error("pin driven during first turnaround bit");
	data_bit_a: assert property (s_data_rise |=> mdio_oe && mdio_out == $past(shift_q[15]))
		else $error("read data bit not driven msb first");
	data_release_a: assert property (s_data_end |=> !mdio_oe && state_q == pcqs_pkg::S_PRE)
		else $error("pin not released after last data bit");
	oe_window_a: assert property (mdio_oe == (state_q == pcqs_pkg::S_RDATA))
		else $error("pin driven outside read data phase");
	anp_write_a: assert property (cfg_we |=> cfg.alt_next_page_enable == $past(wr_word[pcqs_pkg::CFG_ANP_BIT]))
		else $error("alternate next page not written");
	cfg_hold_a: assert property (!cfg_we |=> $stable(cfg))
		else $error("configuration changed without a write");
	write_ignore_a: assert property (wr_stb && reg_q != pcqs_pkg::REG_CFG |=> $stable(cfg))
		else $error("write to other register changed configuration");
	fef_load_a: assert property (s_cfg_load |=> shift_q[pcqs_pkg::CFG_FEF_BIT] == $past(cfg.far_end_fault_enable))
		else $error("far-end fault bit not read back");
	anp_load_a: assert property (s_cfg_load |=> shift_q[pcqs_pkg::CFG_ANP_BIT] == $past(cfg.alt_next_page_enable))
		else $error("alternate next page bit not read back");
	fiber_load_a: assert property (s_cfg_load |=> shift_q[pcqs_pkg::CFG_FIBER_BIT] == $past(cfg.fiber_mode))
		else $error("fiber bit not read back");

endmodule

// ===== verification/pcqs_mgmt_host.sv
// ==========
// management host model, mdc idles low between frames
module pcqs_mgmt_host (
	input wire logic mclk, // system clock
	input wire logic mdio_wire, // resolved data line
	output logic mdc, // management clock
	output logic mdio_drv, // bit driven by host
	output logic mdio_drv_oe // high while host drives
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle: clock low, line released
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_drv_oe = 1'b0;
	end

	// one frame; mdc high spans 5 mclk and low spans 6 mclk, above the 4 needed
	task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] reg_a, input logic [15:0] wdata,
		output logic [15:0] rdata);
		logic [63:0] frame;
		frame = {32'hffffffff, 2'h1, rd ? 2'h2 : 2'h1, phy, reg_a, 2'h2, wdata};
		rdata = 16'h0;
		for (int i = 0; i < 65; i++) begin
			@(posedge mclk);
			mdio_drv <= (i < 64) ? frame[63 - i] : 1'b1;
			// a read hands the line over from turnaround on
			mdio_drv_oe <= (i < 64) && !(rd && i >= 46);
			repeat (5) @(posedge mclk);
			// data bits 15..0 are sampled at rises 48..63
			if (i >= 48 && i < 64)
				rdata = {rdata[14:0], mdio_wire}; // sampled at the rise after the device launched it
			mdc <= 1'b1;
			repeat (5) @(posedge mclk);
			mdc <= 1'b0;
		end
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ===== verification/testbench.sv
// ==========
// bench for port config and quick status
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] MY_ADDR = 5'h05;
	logic mclk = 1'b0;
	logic rst_n, strap, mdc, mdio_out, mdio_oe, host_drv, host_oe, wire_lvl;
	logic [6:0] pat;
	logic [15:0] rd_val;
	pcqs_pkg::pcqs_live_t live;
	pcqs_pkg::pcqs_cfg_t cfg;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	always #25 mclk = ~mclk;
	// pull-up when nobody drives
	assign wire_lvl = mdio_oe ? mdio_out : (host_oe ? host_drv : 1'b1);

	pcqs_top #(.PORT_ADDR(MY_ADDR)) i_dut (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(wire_lvl),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .media_strap_pin(strap), .live(live), .cfg(cfg));
	pcqs_mgmt_host i_host (.mclk(mclk), .mdio_wire(wire_lvl), .mdc(mdc), .mdio_drv(host_drv),
		.mdio_drv_oe(host_oe));

	// ==========
	// tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] reg_a, output logic [15:0] v);
		i_host.xfer(1'b1, MY_ADDR, reg_a, 16'h0000, v);
	endtask

	task automatic wr(input logic [4:0] phy, input logic [4:0] reg_a, input logic [15:0] d);
		logic [15:0] unused;
		i_host.xfer(1'b0, phy, reg_a, d, unused);
	endtask

	// strap held steady across the whole reset
	task automatic do_reset(input logic s);
		@(posedge mclk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard, about three times the expected run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end

	// ==========
	// scenarios
	initial begin
		rst_n = 1'b0;
		strap = 1'b1;
		live = 7'h00;
		do_reset(1'b1);
		check({13'h0000, cfg}, 16'h0005);
		rd(pcqs_pkg::REG_CFG, rd_val);
		check(rd_val, 16'h0005);
		// each status bit alone, then all, then none
		for (int b = 0; b < 9; b++) begin
			pat = (b < 7) ? (7'h01 << b) : ((b == 7) ? 7'h7f : 7'h00);
			@(posedge mclk);
			live <= pat;
			rd(pcqs_pkg::REG_STATUS, rd_val);
			check(rd_val, {1'h0, pat, 8'h00});
		end
		wr(MY_ADDR, pcqs_pkg::REG_CFG, 16'h0002);
		check({13'h0000, cfg}, 16'h0002);
		rd(pcqs_pkg::REG_CFG, rd_val);
		check(rd_val, 16'h0002);
		wr(MY_ADDR, pcqs_pkg::REG_CFG, 16'h0001);
		check({13'h0000, cfg}, 16'h0001);
		// frame for another port must be ignored
		wr(5'h03, pcqs_pkg::REG_CFG, 16'h0006);
		check({13'h0000, cfg}, 16'h0001);
		// status is read only, live state still shows through
		@(posedge mclk);
		live <= 7'h7f;
		wr(MY_ADDR, pcqs_pkg::REG_STATUS, 16'h0000);
		check({13'h0000, cfg}, 16'h0001);
		rd(pcqs_pkg::REG_STATUS, rd_val);
		check(rd_val, 16'h7f00);
		// unmapped address reads zero
		rd(5'h1f, rd_val);
		check(rd_val, 16'h0000);
		do_reset(1'b0);
		check({13'h0000, cfg}, 16'h0004);
		rd(pcqs_pkg::REG_CFG, rd_val);
		check(rd_val, 16'h0004);
		complete_run();
	end
endmodule
